/* logic/prescaler_pkg.sv */
package prescaler_pkg;
    // cycle figures of the divider, in input clock counts
    localparam int RATIO_FULL      = 512;  // both selects high
    localparam int SHORT_A         = 2;    // count removed by select a
    localparam int SHORT_B         = 32;   // counts removed by select b
    localparam int STAGE_MOD       = 16;   // nominal modulus of each cascaded counter
    // cascaded counter widths and reset values
    localparam int CNT_W           = 4;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic       OUT_RST = 1'b1;
    // output high for the first half of the nominal cycle
    localparam logic [3:0] HI_FALL = 4'h8;  // upper counter value where the output falls
endpackage

/* logic/sync_three.sv */
`timescale 1ns/10ps
// three flop synchroniser; a change counts once stages two and three agree
module sync_three (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_async,
    output logic      o_level
);
    // packed state of the synchroniser
    typedef struct packed {
        logic s1;   // first stage, only read by s2
        logic s2;
        logic s3;
        logic lvl;  // agreed level
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // next state: shift and filter
    always_comb begin
        nxt_state     = state_ff;
        nxt_state.s1  = i_async;
        nxt_state.s2  = state_ff.s1;
        nxt_state.s3  = state_ff.s2;
        // only an agreed pair moves the level
        if (state_ff.s2 == state_ff.s3) begin
            nxt_state.lvl = state_ff.s3;
        end
        // selects idle high, like an open pin
        if (!i_reset_n) begin
            nxt_state = 4'hF;
        end
    end

    // register the state
    always_ff @(posedge i_mclk) begin
        state_ff <= nxt_state;
    end

    assign o_level = state_ff.lvl;
endmodule

/* logic/four_modulus_prescaler.sv */
`timescale 1ns/10ps
module four_modulus_prescaler (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_mod_a_n,
    input  wire logic i_mod_b_n,
    output logic      o_div_out
);
    import prescaler_pkg::*;

    logic mod_a_n_s;  // synchronised select a
    logic mod_b_n_s;  // synchronised select b

    // selects come from the controller's domain, so they are synchronised
    // the sync costs a few counts of latency; the controller has hundreds to spare for select a but under 32 for select b
    sync_three u_sync_a (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_mod_a_n),
        .o_level   (mod_a_n_s)
    );
    sync_three u_sync_b (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_mod_b_n),
        .o_level   (mod_b_n_s)
    );

    // whole divider state
    typedef struct packed {
        logic             half;   // front end divide-by-two phase
        logic [CNT_W-1:0] lo;     // first 15/16 counter
        logic [CNT_W-1:0] hi;     // second 15/16 counter
        logic             a_done; // select a already swallowed this cycle
        logic             b_done; // select b already swallowed this cycle
        logic             out;    // divided output
    } div_state_t;

    div_state_t state_ff;
    div_state_t nxt_state;

    // advance one input count
    always_comb begin
        logic lo_wrap;
        logic lo_skip;
        logic hi_skip;
        nxt_state = state_ff;
        lo_wrap   = 1'b0;
        lo_skip   = 1'b0;
        hi_skip   = 1'b0;
        nxt_state.half = ~state_ff.half;
        if (state_ff.half) begin
            // select a: low counter runs as /15 once, i.e. 2 input counts
            // taken in the last low pass before the fall
            // a before fall
            // the pass loses one low step, so the low counter wraps a step early
            if (!mod_a_n_s && !state_ff.a_done && state_ff.hi == (HI_FALL - 4'h1)
                && state_ff.lo == 4'(STAGE_MOD - 2)) begin
                lo_skip          = 1'b1;
                nxt_state.a_done = 1'b1;
            end
            // low counter wraps after its last step, or early when a is swallowed
            lo_wrap = (state_ff.lo == 4'(STAGE_MOD - 1)) || lo_skip;
            nxt_state.lo = lo_wrap ? CNT_RST : state_ff.lo + 4'h1;
            if (lo_wrap) begin
                // select b: high counter runs as /15 once, 32 input counts
                if (!mod_b_n_s && !state_ff.b_done && state_ff.hi == HI_FALL) begin
                    hi_skip          = 1'b1;
                    nxt_state.b_done = 1'b1;
                end
                nxt_state.hi = hi_skip ? HI_FALL + 4'h2 : state_ff.hi + 4'h1;
                // single fall at hi == 8
                if (nxt_state.hi == HI_FALL) begin
                    nxt_state.out = 1'b0;
                end
                // cycle restarts at wrap, output rises
                if (nxt_state.hi == CNT_RST) begin
                    nxt_state.out    = 1'b1;
                    nxt_state.a_done = 1'b0;
                    nxt_state.b_done = 1'b0;
                end
            end
        end
        if (!i_reset_n) begin
            nxt_state        = '0;
            nxt_state.lo     = CNT_RST;
            nxt_state.hi     = CNT_RST;
            nxt_state.out    = OUT_RST;
        end
    end

    // register the state
    always_ff @(posedge i_mclk) begin
        state_ff <= nxt_state;
    end

    assign o_div_out = state_ff.out;

    // helper: counts input cycles between falling output edges
    logic [9:0] gap_ff;
    logic       seen_ff;
    logic       fall;
    assign fall = state_ff.out && !nxt_state.out && i_reset_n;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || fall) begin
            gap_ff  <= 10'h001;
        end else begin
            gap_ff  <= gap_ff + 10'h001;
        end
        if (!i_reset_n) begin
            seen_ff <= 1'b0;
        end else if (fall) begin
            seen_ff <= 1'b1;
        end
    end

    // helper: selects now and one edge ago, and whether they moved in this gap
    logic [1:0] sel_now;       // synchronised selects at this edge
    logic [1:0] sel_last_ff;   // synchronised selects at the previous edge
    logic       sel_moved_ff;  // a select changed since the last fall
    assign sel_now = {mod_a_n_s, mod_b_n_s};
    // a gap has a known length only when the selects held all through it;
    // the clear at the fall wins, since the new values rule the next gap
    always_ff @(posedge i_mclk) begin
        sel_last_ff <= sel_now;
        if (!i_reset_n || fall) begin
            sel_moved_ff <= 1'b0;
        end else if (sel_now != sel_last_ff) begin
            sel_moved_ff <= 1'b1;
        end
    end

    // helper: counts input cycles since the last output edge of either sense
    logic       rise;      // output about to rise at this edge
    logic [9:0] phase_ff;  // length of the running high or low phase
    assign rise = !state_ff.out && nxt_state.out && i_reset_n;
    always_ff @(posedge i_mclk) begin
        // reset leaves the output high, so the first high phase counts from here
        if (!i_reset_n || fall || rise) begin
            phase_ff <= 10'h001;
        end else begin
            phase_ff <= phase_ff + 10'h001;
        end
    end

    property p_ratio;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (fall && seen_ff && !sel_moved_ff && sel_now == sel_last_ff)
            |-> gap_ff == 10'(RATIO_FULL - (mod_a_n_s ? 0 : SHORT_A)
                              - (mod_b_n_s ? 0 : SHORT_B));
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong");

    property p_one_fall;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (fall && seen_ff) |-> gap_ff >= 10'(RATIO_FULL - SHORT_A - SHORT_B);
    endproperty
    a_one_fall: assert property (p_one_fall) else $error("double fall");

    property p_fall_pos;
        @(posedge i_mclk) disable iff (!i_reset_n)
        fall |-> nxt_state.hi == HI_FALL && nxt_state.lo == CNT_RST;
    endproperty
    a_fall_pos: assert property (p_fall_pos) else $error("fall misplaced");

    property p_half;
        @(posedge i_mclk) disable iff (!i_reset_n)
        $rose(state_ff.half) |=> $fell(state_ff.half);
    endproperty
    a_half: assert property (p_half) else $error("front end stuck");

    property p_lo_range;
        @(posedge i_mclk) disable iff (!i_reset_n)
        state_ff.lo != CNT_RST && $past(state_ff.lo) != state_ff.lo
            |-> state_ff.lo == $past(state_ff.lo) + 4'h1;
    endproperty
    a_lo_range: assert property (p_lo_range) else $error("low counter skip");

    property p_full;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (fall && mod_a_n_s && mod_b_n_s) |-> gap_ff <= 10'(RATIO_FULL);
    endproperty
    a_full: assert property (p_full) else $error("cycle too long");

    property p_high_len;
        @(posedge i_mclk) disable iff (!i_reset_n)
        fall |-> (phase_ff == 10'(RATIO_FULL / 2)
                  || phase_ff == 10'(RATIO_FULL / 2 - SHORT_A));
    endproperty
    a_high_len: assert property (p_high_len) else $error("high phase wrong");

    property p_low_len;
        @(posedge i_mclk) disable iff (!i_reset_n)
        rise |-> (phase_ff == 10'(RATIO_FULL / 2)
                  || phase_ff == 10'(RATIO_FULL / 2 - SHORT_B));
    endproperty
    a_low_len: assert property (p_low_len) else $error("low phase wrong");

    property p_hi_step;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (state_ff.hi != $past(state_ff.hi))
            |-> (state_ff.hi == $past(state_ff.hi) + 4'h1)
                || ($past(state_ff.hi) == HI_FALL && state_ff.hi == HI_FALL + 4'h2);
    endproperty
    a_hi_step: assert property (p_hi_step) else $error("upper counter skip");
endmodule

/* verification/synth_ctrl_model.sv */
`timescale 1ns/10ps
// controller model: retimes the wanted selects onto the divided output's fall
module synth_ctrl_model (
    input  wire logic i_mclk,
    input  wire logic i_div,
    input  wire logic i_want_a_n,
    input  wire logic i_want_b_n,
    output logic      o_mod_a_n,
    output logic      o_mod_b_n
);
    logic div_prev_ff;  // output level seen at the last edge
    // selects idle high, as the pull-ups would leave them
    initial begin
        o_mod_a_n   = 1'b1;
        o_mod_b_n   = 1'b1;
        div_prev_ff = 1'b1;
    end
    always @(posedge i_mclk) begin
        if (div_prev_ff && !i_div) begin
            o_mod_a_n <= #1 i_want_a_n;
            o_mod_b_n <= #1 i_want_b_n;
        end
        div_prev_ff <= i_div;
    end
endmodule

/* verification/test_four_modulus_prescaler.sv */
`timescale 1ns/10ps
module test_four_modulus_prescaler;
    import prescaler_pkg::*;
    logic i_mclk;     // input clock
    logic i_reset_n;  // reset, active low
    logic mod_a_n;    // select a from the model
    logic mod_b_n;    // select b from the model
    logic want_a_n;   // select a asked of the model
    logic want_b_n;   // select b asked of the model
    logic o_div_out;  // divided output
    int   err_total = 0;
    int   tests_run = 0;
    four_modulus_prescaler DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_mod_a_n(mod_a_n), .i_mod_b_n(mod_b_n), .o_div_out(o_div_out));
    synth_ctrl_model ctrl (.i_mclk(i_mclk), .i_div(o_div_out), .i_want_a_n(want_a_n),
        .i_want_b_n(want_b_n), .o_mod_a_n(mod_a_n), .o_mod_b_n(mod_b_n));
    // free running input clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // output must sit high while reset is held
    task test_reset_level;
        repeat (4) @(posedge i_mclk);
        // look once the edge has settled, then release in the same slot
        #1;
        check("div_out in reset", {15'h0, o_div_out}, {15'h0, OUT_RST});
        i_reset_n = 1'b1;
    endtask
    // one full cycle after the selects change: high and low phase lengths
    task test_ratio(input logic a_n, input logic b_n);
        int hi;
        int lo;
        int exp_p;
        hi = 0;
        lo = 0;
        exp_p = RATIO_FULL - (a_n ? 0 : SHORT_A) - (b_n ? 0 : SHORT_B);
        @(posedge i_mclk);
        #1 want_a_n = a_n;
        want_b_n = b_n;
        @(negedge o_div_out);
        while (o_div_out !== 1'b1) @(negedge i_mclk);
        while (o_div_out === 1'b1 && hi < 600) begin
            hi++;
            @(negedge i_mclk);
        end
        while (o_div_out === 1'b0 && lo < 600) begin
            lo++;
            @(negedge i_mclk);
        end
        check("high phase", 16'(hi), 16'(RATIO_FULL / 2 - (a_n ? 0 : SHORT_A)));
        check("low phase", 16'(lo), 16'(RATIO_FULL / 2 - (b_n ? 0 : SHORT_B)));
        check("period", 16'(hi + lo), 16'(exp_p));
    endtask
    // hang guard, well past the expected run length
    initial begin
        #300000;
        err_total++;
        stop_test();
    end
    initial begin
        i_reset_n = 1'b0;
        want_a_n  = 1'b1;
        want_b_n  = 1'b1;
        test_reset_level();
        test_ratio(1'b1, 1'b1);
        test_ratio(1'b0, 1'b1);
        test_ratio(1'b1, 1'b0);
        test_ratio(1'b0, 1'b0);
        test_ratio(1'b1, 1'b1);
        stop_test();
    end
endmodule
